// File: rtl/acc_pkg.sv
// Constants shared by the comparator control block and its helpers.
package acc_pkg;

  // ==========================================================================
  // Bus and pin geometry
  localparam int ACC_ADDR_W = 4;
  localparam int ACC_DATA_W = 8;
  localparam int ACC_PINS = 4;
  localparam int ACC_SYNC_STAGES = 2;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] ACC_OFF_CTRL = 4'h0;
  localparam logic [3:0] ACC_OFF_STAT = 4'h1;
  localparam logic [3:0] ACC_OFF_MASK = 4'h2;
  localparam logic [3:0] ACC_OFF_FSEL_IN = 4'h3;
  localparam logic [3:0] ACC_OFF_FSEL_OUT = 4'h4;
  localparam logic [3:0] ACC_OFF_PULL = 4'h5;
  localparam logic [3:0] ACC_OFF_PDATA = 4'h6;
  localparam logic [3:0] ACC_OFF_PDIR = 4'h7;
  localparam logic [3:0] ACC_OFF_FLAG_SET = 4'h8;

  // ==========================================================================
  // Control register fields and reset values
  localparam int ACC_BIT_POWER = 6;
  localparam int ACC_BIT_INVERT = 5;
  localparam int ACC_BIT_RESULT = 4;
  localparam int ACC_BIT_HYST = 0;
  localparam int ACC_BIT_FLAG = 0;
  localparam logic [7:0] ACC_CTRL_RESET = 8'h01;
  localparam logic [7:0] ACC_CTRL_RO_ZERO = 8'h8e;
  localparam logic [3:0] ACC_DIR_RESET = 4'hf;

endpackage

// File: rtl/acc_pin_if.sv
// Carrier between the control core and the shared-pin multiplexer.
interface acc_pin_if #(
  parameter int N = 4
);
  logic [N-1:0] fsel_in;
  logic [N-1:0] fsel_out;
  logic [N-1:0] pull_cfg;
  logic [N-1:0] latch;
  logic [N-1:0] dir;
  logic result;
  logic [N-1:0] read_val;

  modport ctl (output fsel_in, output fsel_out, output pull_cfg, output latch, output dir, output result,
    input read_val);
  modport mux (input fsel_in, input fsel_out, input pull_cfg, input latch, input dir, input result,
    output read_val);
endinterface

// File: rtl/acc_sync.sv
// Two flip-flop synchroniser for the raw analog comparator output.
module acc_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic sync_reg;

  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// File: rtl/acc_pinmux.sv
// Shared I/O pin steering for comparator inputs and output.
module acc_pinmux #(
  parameter int N = 4
) (
  acc_pin_if.mux pins,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe,
  output logic [N-1:0] pin_pull_en
);
  // ==========================================================================
  // Per-pin steering, one copy per pin
  for (genvar i = 0; i < N; i++) begin : g_pin
    logic cmp_fn;
    assign cmp_fn = pins.fsel_in[i] | pins.fsel_out[i];
    // Comparator function masks the pad: input-direction reads zero, output reads latch
    assign pins.read_val[i] = cmp_fn ? (pins.dir[i] ? 1'b0 : pins.latch[i]) : pin_in[i];
    // Pull-high would load the analog input, so it drops out
    assign pin_pull_en[i] = pins.pull_cfg[i] & ~pins.fsel_in[i];
    assign pin_out[i] = pins.fsel_out[i] ? pins.result : pins.latch[i];
    assign pin_oe[i] = pins.fsel_out[i] | (~pins.fsel_in[i] & ~pins.dir[i]);
  end
endmodule

// File: rtl/acc_top.sv
// Analog comparator control: register file, result path, interrupt and wake.
// ============================================================================
// What this block does
// - A cleared enable bit powers the comparator core down.
// - Clearing the enable bit forces the result bit low.
// - Polarity bit zero passes the raw output, one inverts it.
// - The result bit is read-only and reflects the compared inputs under the polarity.
// - The hysteresis bit turns hysteresis on when set and is set after reset.
// - Control bits 7 and 3 to 1 always read as zero.
// - Every change of the result bit sets the comparator interrupt flag.
// - A set flag with its enable set requests the comparator interrupt.
// - In sleep or idle with the comparator on, a change that sets a clear flag also wakes the device.
// - An enabled comparator keeps working during sleep or idle.
// - With the comparator function on a pin, its port read gives zero for input direction, else the latch.
// - Selecting a comparator input function on a pin removes its pull-high.
// - The result can be driven onto a shared output pin when that function is selected.
module acc_top
  import acc_pkg::*;
#(
  parameter int N = acc_pkg::ACC_PINS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [acc_pkg::ACC_ADDR_W-1:0] reg_addr,
  input wire logic [acc_pkg::ACC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [acc_pkg::ACC_DATA_W-1:0] reg_rdata,
  input wire logic cmp_raw,
  input wire logic low_power,
  output logic comparator_power_on,
  output logic hysteresis_on,
  output logic irq,
  output logic wake,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe,
  output logic [N-1:0] pin_pull_en
);
  import acc_pkg::*;

  // ==========================================================================
  // State
  logic power_reg, power_next;
  logic invert_reg, invert_next;
  logic hyst_reg, hyst_next;
  logic result_reg, result_next;
  logic flag_reg, flag_next;
  logic mask_reg, mask_next;
  logic wake_reg, wake_next;
  logic [N-1:0] fin_reg, fin_next;
  logic [N-1:0] fout_reg, fout_next;
  logic [N-1:0] pull_reg, pull_next;
  logic [N-1:0] latch_reg, latch_next;
  logic [N-1:0] dir_reg, dir_next;
  logic [ACC_DATA_W-1:0] rdata_reg, rdata_next;
  logic raw_sync;
  logic cmp_event;
  logic [ACC_DATA_W-1:0] ctrl_view;

  acc_pin_if #(.N(N)) pin_bus ();

  // ==========================================================================
  // Raw comparator output into the clock domain
  acc_sync u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(cmp_raw),
    .sync_out(raw_sync)
  );

  acc_pinmux #(.N(N)) u_pinmux (
    .pins(pin_bus.mux),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_pull_en(pin_pull_en)
  );

  assign pin_bus.fsel_in = fin_reg;
  assign pin_bus.fsel_out = fout_reg;
  assign pin_bus.pull_cfg = pull_reg;
  assign pin_bus.latch = latch_reg;
  assign pin_bus.dir = dir_reg;
  assign pin_bus.result = result_reg;

  // ==========================================================================
  // Control register as software sees it, unused bits tied low
  always_comb begin
    ctrl_view = '0;
    ctrl_view[ACC_BIT_POWER] = power_reg;
    ctrl_view[ACC_BIT_INVERT] = invert_reg;
    ctrl_view[ACC_BIT_RESULT] = result_reg;
    ctrl_view[ACC_BIT_HYST] = hyst_reg;
  end

  // Result path; a disabled core reads low whatever the pads do
  always_comb begin
    if (power_reg) begin
      result_next = raw_sync ^ invert_reg;
    end else begin
      result_next = 1'b0;
    end
  end

  // Any change of the result is an interrupt event, including the forced drop at disable
  assign cmp_event = result_next != result_reg;

  // ==========================================================================
  // Register writes, flag and wake
  always_comb begin
    power_next = power_reg;
    invert_next = invert_reg;
    hyst_next = hyst_reg;
    mask_next = mask_reg;
    fin_next = fin_reg;
    fout_next = fout_reg;
    pull_next = pull_reg;
    latch_next = latch_reg;
    dir_next = dir_reg;
    flag_next = flag_reg;
    if (reg_wr) begin
      case (reg_addr)
        ACC_OFF_CTRL: begin
          // Result bit is not writable
          power_next = reg_wdata[ACC_BIT_POWER];
          invert_next = reg_wdata[ACC_BIT_INVERT];
          hyst_next = reg_wdata[ACC_BIT_HYST];
        end
        ACC_OFF_STAT: begin
          flag_next = flag_reg & ~reg_wdata[ACC_BIT_FLAG];
        end
        ACC_OFF_MASK: begin
          mask_next = reg_wdata[ACC_BIT_FLAG];
        end
        ACC_OFF_FSEL_IN: begin
          fin_next = reg_wdata[N-1:0];
        end
        ACC_OFF_FSEL_OUT: begin
          fout_next = reg_wdata[N-1:0];
        end
        ACC_OFF_PULL: begin
          pull_next = reg_wdata[N-1:0];
        end
        ACC_OFF_PDATA: begin
          latch_next = reg_wdata[N-1:0];
        end
        ACC_OFF_PDIR: begin
          dir_next = reg_wdata[N-1:0];
        end
        ACC_OFF_FLAG_SET: begin
          // Lets software pre-arm the flag so sleep is not broken
          flag_next = flag_reg | reg_wdata[ACC_BIT_FLAG];
        end
        default: begin
          flag_next = flag_reg;
        end
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (cmp_event) begin
      flag_next = 1'b1;
    end
    // Wake only on a fresh flag, so a pre-set flag suppresses it
    wake_next = low_power & power_reg & cmp_event & ~flag_reg;
  end

  // ==========================================================================
  // Read mux, data valid the cycle after the strobe only
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        ACC_OFF_CTRL: rdata_next = ctrl_view;
        ACC_OFF_STAT: rdata_next[ACC_BIT_FLAG] = flag_reg;
        ACC_OFF_MASK: rdata_next[ACC_BIT_FLAG] = mask_reg;
        ACC_OFF_FSEL_IN: rdata_next[N-1:0] = fin_reg;
        ACC_OFF_FSEL_OUT: rdata_next[N-1:0] = fout_reg;
        ACC_OFF_PULL: rdata_next[N-1:0] = pull_reg;
        ACC_OFF_PDATA: rdata_next[N-1:0] = pin_bus.read_val;
        ACC_OFF_PDIR: rdata_next[N-1:0] = dir_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  // ==========================================================================
  // All state registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      power_reg <= ACC_CTRL_RESET[ACC_BIT_POWER];
      invert_reg <= ACC_CTRL_RESET[ACC_BIT_INVERT];
      hyst_reg <= ACC_CTRL_RESET[ACC_BIT_HYST];
      result_reg <= ACC_CTRL_RESET[ACC_BIT_RESULT];
      flag_reg <= 1'b0;
      mask_reg <= 1'b0;
      wake_reg <= 1'b0;
      fin_reg <= '0;
      fout_reg <= '0;
      pull_reg <= '0;
      latch_reg <= '0;
      dir_reg <= ACC_DIR_RESET[N-1:0];
      rdata_reg <= '0;
    end else begin
      power_reg <= power_next;
      invert_reg <= invert_next;
      hyst_reg <= hyst_next;
      result_reg <= result_next;
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      wake_reg <= wake_next;
      fin_reg <= fin_next;
      fout_reg <= fout_next;
      pull_reg <= pull_next;
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata = rdata_reg;
  assign comparator_power_on = power_reg;
  assign hysteresis_on = hyst_reg;
  assign irq = flag_reg & mask_reg;
  assign wake = wake_reg;

  // ==========================================================================
  // Checks
  sequence s_write_off;
    reg_wr && reg_addr == ACC_OFF_CTRL && !reg_wdata[ACC_BIT_POWER];
  endsequence

  sequence s_drop;
    !comparator_power_on ##1 !result_reg;
  endsequence

  sequence s_sleep_change;
    low_power && power_reg && !flag_reg && cmp_event;
  endsequence

  property p_power_off;
    @(posedge clk_sys) disable iff (!nrst)
    s_write_off |=> s_drop;
  endproperty
  a_power_off: assert property (p_power_off) else $error("core not powered down");

  property p_forced_low;
    @(posedge clk_sys) disable iff (!nrst)
    !power_reg |=> !result_reg;
  endproperty
  a_forced_low: assert property (p_forced_low) else $error("result not forced low");

  property p_polarity;
    @(posedge clk_sys) disable iff (!nrst)
    power_reg |=> result_reg == ($past(raw_sync) ^ $past(invert_reg));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_read_result;
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && reg_addr == ACC_OFF_CTRL |=> reg_rdata[ACC_BIT_RESULT] == $past(result_reg);
  endproperty
  a_read_result: assert property (p_read_result) else $error("result read wrong");

  property p_hyst_write;
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && reg_addr == ACC_OFF_CTRL |=> hysteresis_on == $past(reg_wdata[ACC_BIT_HYST]);
  endproperty
  a_hyst_write: assert property (p_hyst_write) else $error("hysteresis bit wrong");

  property p_zero_bits;
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && reg_addr == ACC_OFF_CTRL |=> (reg_rdata & ACC_CTRL_RO_ZERO) == 8'h00;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero");

  property p_flag_set;
    @(posedge clk_sys) disable iff (!nrst)
    $changed(result_reg) |-> flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag missed a change");

  property p_irq;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(flag_reg) && mask_reg |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_wake;
    @(posedge clk_sys) disable iff (!nrst)
    s_sleep_change |=> wake ##1 !wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake pulse");

  property p_sleep_track;
    @(posedge clk_sys) disable iff (!nrst)
    low_power && power_reg |=> result_reg == ($past(raw_sync) ^ $past(invert_reg));
  endproperty
  a_sleep_track: assert property (p_sleep_track) else $error("stalled in sleep");

  property p_pull;
    @(posedge clk_sys) disable iff (!nrst)
    (pin_pull_en & fin_reg) == '0;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-high left on input");

  property p_out_pin;
    @(posedge clk_sys) disable iff (!nrst)
    (fout_reg & (pin_out ^ {N{result_reg}})) == '0 && (fout_reg & ~pin_oe) == '0;
  endproperty
  a_out_pin: assert property (p_out_pin) else $error("result not on pin");

endmodule

// File: testbench/acc_partner.sv
// Behavioural model of the analog comparator core and the shared pads.
module acc_partner
  import acc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic comparator_power_on,
  input wire logic hysteresis_on,
  input var int vpos,
  input var int vneg,
  output logic cmp_raw,
  input wire logic [ACC_PINS-1:0] pin_out,
  input wire logic [ACC_PINS-1:0] pin_oe,
  input wire logic [ACC_PINS-1:0] pin_pull_en,
  input wire logic [ACC_PINS-1:0] pad_ext,
  output logic [ACC_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Core: an unpowered core gives junk, so it flips every cycle
  logic core_q = 1'b0;
  always @(posedge clk_sys) begin
    if (!comparator_power_on) begin
      core_q <= !core_q;
    end else if (!hysteresis_on || vpos > vneg + 2 || vpos < vneg - 2) begin
      core_q <= vpos > vneg;
    end
  end
  assign cmp_raw = core_q;
  // Pads: own drive wins, then pull-high, then the outside source
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pull_en | pad_ext));
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the comparator control block.
module tb
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, low_power = 1'b0;
  logic [3:0] reg_addr = 4'h0, pad_ext = 4'h0, pin_in, pin_out, pin_oe, pin_pull_en;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic cmp_raw, comparator_power_on, hysteresis_on, irq, wake;
  int vpos = 0, vneg = 100, fail_count = 0, num_checks = 0;
  int e_res = 0, e_flag = 0, pwr = 0, inv = 0, hy = 1;

  // ==========================================================================
  // Clock, design and far side
  always #5 clk_sys = ~clk_sys;
  acc_top i_dut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_raw,
    .low_power, .comparator_power_on, .hysteresis_on, .irq, .wake, .pin_in, .pin_out, .pin_oe,
    .pin_pull_en);
  acc_partner i_far (.clk_sys, .comparator_power_on, .hysteresis_on, .vpos, .vneg, .cmp_raw,
    .pin_out, .pin_oe, .pin_pull_en, .pad_ext, .pin_in);

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard: a stuck run counts as a mismatch
  initial begin
    #900000;
    fail_count++;
    results();
  end

  // ==========================================================================
  // Register bus: strobes one cycle, read data one cycle after
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Let the landing edge settle before anyone looks at outputs
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // ==========================================================================
  // Reference model of the control register and result flag
  function automatic logic [7:0] ectrl();
    return {1'b0, pwr[0], inv[0], e_res[0], 3'h0, hy[0]};
  endfunction
  // Four edges cover the far side, the two sync stages and the result flop
  task automatic settle(input int p, input int n);
    int r;
    @(posedge clk_sys);
    vpos <= p;
    vneg <= n;
    repeat (4) @(posedge clk_sys);
    r = pwr ? ((p > n) ^ inv) : 0;
    if (r != e_res) e_flag = 1;
    e_res = r;
  endtask
  // Ones go to the read-only and unused bits on purpose
  task automatic wctrl(input int p, input int i, input int h);
    pwr = p;
    inv = i;
    hy = h;
    wr(ACC_OFF_CTRL, {1'b1, p[0], i[0], 1'b1, 3'h7, h[0]});
    settle(vpos, vneg);
  endtask
  task automatic watch(input int p, input int n, output logic seen);
    seen = 1'b0;
    @(posedge clk_sys);
    vpos <= p;
    vneg <= n;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (wake === 1'b1) seen = 1'b1;
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic seen;
    logic [3:0] fi, fo, pu, dr, la, oe, po, pad;
    int n;
    n = $urandom(84476);
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    rchk(ACC_OFF_CTRL, ACC_CTRL_RESET);
    chk(8'({comparator_power_on, hysteresis_on, irq}), 8'h02);
    $display("test reset done");
    // Random inputs, polarity and hysteresis against the model
    wr(ACC_OFF_MASK, 8'h01);
    wctrl(1, 0, 1);
    // Power-up lets junk from the idle core through, so start from a clear flag
    wr(ACC_OFF_STAT, 8'h01);
    e_flag = 0;
    for (int k = 0; k < 24; k++) begin
      if (k % 6 == 5) wctrl(1, $urandom % 2, $urandom % 2);
      n = $urandom % 100;
      settle(($urandom % 2) ? n + 50 : n, n + 25);
      rchk(ACC_OFF_CTRL, ectrl());
      rchk(ACC_OFF_STAT, 8'(e_flag));
      chk(8'(irq), 8'(e_flag));
      chk(8'({comparator_power_on, hysteresis_on}), {6'h0, 1'b1, hy[0]});
      wr(ACC_OFF_STAT, 8'h01);
      e_flag = 0;
    end
    $display("test compare done");
    // Power down while the result is high
    wctrl(1, 0, 1);
    settle(100, 50);
    wr(ACC_OFF_STAT, 8'h01);
    e_flag = 0;
    wctrl(0, 0, 1);
    rchk(ACC_OFF_CTRL, ectrl());
    rchk(ACC_OFF_STAT, 8'(e_flag));
    chk(8'(comparator_power_on), 8'h00);
    wr(ACC_OFF_MASK, 8'h00);
    chk(8'(irq), 8'h00);
    $display("test power down done");
    // Sleep: wake on a change, none when the flag was set first
    @(posedge clk_sys);
    low_power <= 1'b1;
    wctrl(1, 0, 1);
    wr(ACC_OFF_STAT, 8'h01);
    watch(50, 100, seen);
    chk(8'(seen), 8'h01);
    if (seen !== 1'b1) results();
    e_res = 0;
    rchk(ACC_OFF_STAT, 8'h01);
    wr(ACC_OFF_STAT, 8'h01);
    wr(ACC_OFF_FLAG_SET, 8'h01);
    watch(100, 50, seen);
    chk(8'(seen), 8'h00);
    e_res = 1;
    @(posedge clk_sys);
    low_power <= 1'b0;
    $display("test wake done");
    // Shared pins under random function, pull, direction and latch
    for (int k = 0; k < 6; k++) begin
      fi = 4'($urandom);
      fo = 4'($urandom);
      pu = 4'($urandom);
      dr = 4'($urandom);
      la = 4'($urandom);
      @(posedge clk_sys);
      pad_ext <= 4'($urandom);
      wctrl(1, k % 2, 1);
      wr(ACC_OFF_FSEL_IN, {4'h0, fi});
      wr(ACC_OFF_FSEL_OUT, {4'h0, fo});
      wr(ACC_OFF_PULL, {4'h0, pu});
      wr(ACC_OFF_PDIR, {4'h0, dr});
      wr(ACC_OFF_PDATA, {4'h0, la});
      oe = fo | (~fi & ~dr);
      po = (fo & {4{e_res[0]}}) | (~fo & la);
      pad = (oe & po) | (~oe & ((pu & ~fi) | pad_ext));
      chk({4'h0, pin_pull_en}, {4'h0, pu & ~fi});
      chk({4'h0, pin_oe}, {4'h0, oe});
      chk({4'h0, pin_out}, {4'h0, po});
      rchk(ACC_OFF_PDATA, {4'h0, ((fi | fo) & ~dr & la) | (~(fi | fo) & pad)});
    end
    $display("test pins done");
    // Unmapped places read zero
    for (int a = 9; a < 16; a++) rchk(4'(a), 8'h00);
    $display("test unmapped done");
    results();
  end
endmodule
